// ---- rtl/arhost_pkg.sv ----
// Constants for the receive-context host controller
package arhost_pkg;
   // Own Wishbone register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_BUF_ADDR = 8'h04;
   localparam logic [7:0] REG_BUF_SIZE = 8'h08;
   localparam logic [7:0] REG_REQ_BASE = 8'h0C;
   localparam logic [7:0] REG_RSP_BASE = 8'h10;
   localparam logic [7:0] REG_CMD = 8'h14;
   localparam logic [7:0] REG_STATUS = 8'h18;
   localparam logic [7:0] REG_QUERY = 8'h1C;
   localparam logic [7:0] REG_FILLED = 8'h20;
   // Control register fields
   localparam int CTRL_IRQ_BIT = 0;
   // Command register fields
   localparam logic [3:0] CMD_APPEND = 4'h1;
   localparam logic [3:0] CMD_START = 4'h2;
   localparam logic [3:0] CMD_STOP = 4'h3;
   localparam logic [3:0] CMD_QUERY = 4'h4;
   localparam int CMD_CTX_BIT = 4;
   localparam int CMD_IDX_LSB = 8;
   // Status register fields
   localparam int STAT_ERR_BIT = 16;
   localparam int STAT_BUSY_BIT = 17;
   localparam int STAT_RUN0_BIT = 18;
   localparam int STAT_RUN1_BIT = 19;
   localparam int STAT_CNT1_LSB = 8;
   // Descriptor field values
   localparam logic [3:0] DESC_CMD_FILL = 4'h2;
   localparam logic DESC_STATUS_FLAG = 1'b1;
   localparam logic [2:0] DESC_KEY = 3'b0;
   localparam logic [1:0] DESC_IRQ_ON = 2'b11;
   localparam logic [1:0] DESC_IRQ_OFF = 2'b00;
   localparam logic [1:0] DESC_BRANCH = 2'b11;
   localparam logic [3:0] DESC_Z_MORE = 4'h1;
   localparam logic [3:0] DESC_Z_LAST = 4'h0;
   localparam logic [15:0] DESC_STATUS_INIT = 16'h0000;
   localparam logic [31:0] DESC_NEXT_OFS = 32'h0000_0008;
   localparam logic [31:0] DESC_RESID_OFS = 32'h0000_000C;
   // Device register map, per context
   localparam logic [11:0] DEV_REQ_BASE = 12'h000;
   localparam logic [11:0] DEV_RSP_BASE = 12'h020;
   localparam logic [11:0] DEV_SET_OFS = 12'h000;
   localparam logic [11:0] DEV_CLR_OFS = 12'h004;
   localparam logic [11:0] DEV_PTR_OFS = 12'h00C;
   localparam logic [31:0] DEV_RUN_MASK = 32'h0000_8000;
   localparam logic [31:0] DEV_WAKE_MASK = 32'h0000_1000;
endpackage : arhost_pkg

// ---- rtl/arhost_desc_pack.sv ----
// Builds one quadlet of a receive descriptor
`timescale 1ns/1ns
module arhost_desc_pack (
   input wire logic [31:0] buf_addr_in,
   input wire logic [15:0] buf_size_in,
   input wire logic irq_on_in,
   input wire logic [27:0] next_ptr_in,
   input wire logic [3:0] z_in,
   input wire logic [1:0] sel_in,
   output logic [31:0] quadlet_out
);
   logic [1:0] irq_code;

   assign irq_code = irq_on_in ? arhost_pkg::DESC_IRQ_ON : arhost_pkg::DESC_IRQ_OFF;

   always_comb begin
      case (sel_in)
         2'h0: quadlet_out = {arhost_pkg::DESC_CMD_FILL, arhost_pkg::DESC_STATUS_FLAG, arhost_pkg::DESC_KEY,
                     2'b00, irq_code, arhost_pkg::DESC_BRANCH, 2'b00, buf_size_in};
         2'h1: quadlet_out = buf_addr_in;
         2'h2: quadlet_out = {next_ptr_in, z_in};
         default: quadlet_out = {arhost_pkg::DESC_STATUS_INIT, buf_size_in};
      endcase
   end
endmodule : arhost_desc_pack

// ---- rtl/arhost_size_mem.sv ----
// Shadow table of buffer sizes, registered read
`timescale 1ns/1ns
module arhost_size_mem #(
   parameter int ADDR_W = 5,
   parameter int DATA_W = 16
) (
   input wire logic clk_sys_in,
   input wire logic we_in,
   input wire logic [ADDR_W-1:0] addr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   output logic [DATA_W-1:0] rdata_out
);
   logic [DATA_W-1:0] store [2**ADDR_W];

   always_ff @(posedge clk_sys_in) begin
      if (we_in) begin
         store[addr_in] <= wdata_in;
      end
      rdata_out <= store[addr_in];
   end
endmodule : arhost_size_mem

// ---- rtl/arhost_ctrl.sv ----
// Host-side controller that builds receive programs and drives both contexts
`timescale 1ns/1ns
// Functional notes
// - Descriptors sixteen bytes, aligned
// - Command code buffer-fill
// - Status-write flag set
// - Key zero
// - Interrupt select eleven or zero
// - Branch select eleven
// - Buffer size quadlet multiple
// - Buffer address quadlet aligned
// - Next pointer aligned, valid when chained
// - Block count one chained, zero last
// - Append while running, then wake
// - Only last descriptor's link rewritten
// - Own start pointer per context
// - Start pointer low bit marks nonempty
// - Set and clear ports for control
// - Remaining count starts at size
module arhost_ctrl #(
   parameter int DESC_IDX_W = 4,
   parameter int DEV_ADDR_W = 12
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_we_in,
   input wire logic [7:0] wb_adr_in,
   input wire logic [31:0] wb_dat_in,
   input wire logic [3:0] wb_sel_in,
   output logic [31:0] wb_dat_out,
   output logic wb_ack_out,
   output logic mem_req_out,
   output logic mem_we_out,
   output logic [31:0] mem_addr_out,
   output logic [31:0] mem_wdata_out,
   input wire logic [31:0] mem_rdata_in,
   input wire logic mem_ack_in,
   output logic dev_req_out,
   output logic [DEV_ADDR_W-1:0] dev_addr_out,
   output logic [31:0] dev_wdata_out,
   input wire logic dev_ack_in
);
   typedef enum logic [3:0] {
      ST_IDLE, ST_DESC_WR, ST_LINK_WR, ST_PTR_WR, ST_SET_WR, ST_CLR_WR, ST_QUERY_RD, ST_QUERY_FIN, ST_FINISH
   } arhost_state_type;

   localparam logic [DESC_IDX_W:0] MAX_DESC = (DESC_IDX_W+1)'(2**DESC_IDX_W);

   logic [1:0] rst_sync;
   logic rst_b;
   arhost_state_type st;
   logic [31:0] buf_addr;
   logic [15:0] buf_size;
   logic irq_on;
   logic [31:0] ctx_base [2];
   logic [DESC_IDX_W:0] desc_count [2];
   logic started [2];
   logic [3:0] cmd_code;
   logic cmd_ctx;
   logic [DESC_IDX_W-1:0] cmd_idx;
   logic cmd_go;
   logic err;
   logic refuse;
   logic [3:0] op_code;
   logic op_ctx;
   logic [1:0] quad;
   logic [31:0] query_status;
   logic [15:0] query_filled;
   logic [15:0] size_q;
   logic wb_hit;
   logic wb_wr;
   logic [31:0] pack_q;
   logic [15:0] size_rd;
   logic size_we;
   logic [DESC_IDX_W:0] size_addr;
   logic append_bad;
   logic [DESC_IDX_W:0] op_idx;
   logic [DEV_ADDR_W-1:0] dev_base;
   logic [31:0] cur_desc;

   function automatic logic [31:0] desc_addr(input logic [31:0] base, input logic [DESC_IDX_W:0] idx);
      return base + {{(27-DESC_IDX_W){1'b0}}, idx, 4'h0};
   endfunction : desc_addr

   function automatic logic [31:0] merge_sel(input logic [31:0] old, input logic [31:0] wdat, input logic [3:0] sel);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            res[8*b +: 8] = wdat[8*b +: 8];
         end
      end
      return res;
   endfunction : merge_sel

   // Reset release through two flops
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_b = rst_sync[1];

   assign wb_hit = wb_cyc_in && wb_stb_in && !wb_ack_out;
   assign wb_wr = wb_hit && wb_we_in;
   assign op_idx = desc_count[op_ctx];
   assign dev_base = op_ctx ? arhost_pkg::DEV_RSP_BASE : arhost_pkg::DEV_REQ_BASE;
   assign cur_desc = desc_addr(ctx_base[op_ctx], op_idx);
   assign append_bad = (buf_addr[1:0] != 2'b00) || (buf_size[1:0] != 2'b00)
                       || (ctx_base[cmd_ctx][3:0] != 4'h0) || (desc_count[cmd_ctx] == MAX_DESC);
   assign size_addr = {cmd_ctx, (cmd_code == arhost_pkg::CMD_APPEND) ? desc_count[cmd_ctx][DESC_IDX_W-1:0] : cmd_idx};
   assign size_we = cmd_go && (cmd_code == arhost_pkg::CMD_APPEND) && !append_bad;

   arhost_desc_pack u_pack (
      .buf_addr_in(buf_addr),
      .buf_size_in(buf_size),
      .irq_on_in(irq_on),
      .next_ptr_in(28'h0000000),
      .z_in(arhost_pkg::DESC_Z_LAST),
      .sel_in(quad),
      .quadlet_out(pack_q)
   );

   arhost_size_mem #(.ADDR_W(DESC_IDX_W+1), .DATA_W(16)) u_sizes (
      .clk_sys_in(clk_sys_in),
      .we_in(size_we),
      .addr_in(size_addr),
      .wdata_in(buf_size),
      .rdata_out(size_rd)
   );

   // Wishbone handshake and read data
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= '0;
      end else begin
         wb_ack_out <= wb_hit;
         wb_dat_out <= '0;
         if (wb_hit && !wb_we_in) begin
            case (wb_adr_in)
               arhost_pkg::REG_CTRL: wb_dat_out <= {31'h0, irq_on};
               arhost_pkg::REG_BUF_ADDR: wb_dat_out <= buf_addr;
               arhost_pkg::REG_BUF_SIZE: wb_dat_out <= {16'h0000, buf_size};
               arhost_pkg::REG_REQ_BASE: wb_dat_out <= ctx_base[0];
               arhost_pkg::REG_RSP_BASE: wb_dat_out <= ctx_base[1];
               arhost_pkg::REG_CMD: wb_dat_out <= {16'h0000, {(8-DESC_IDX_W){1'b0}}, cmd_idx, 3'b000, cmd_ctx, cmd_code};
               arhost_pkg::REG_STATUS: begin
                  wb_dat_out[DESC_IDX_W:0] <= desc_count[0];
                  wb_dat_out[arhost_pkg::STAT_CNT1_LSB +: DESC_IDX_W+1] <= desc_count[1];
                  wb_dat_out[arhost_pkg::STAT_ERR_BIT] <= err;
                  wb_dat_out[arhost_pkg::STAT_BUSY_BIT] <= (st != ST_IDLE);
                  wb_dat_out[arhost_pkg::STAT_RUN0_BIT] <= started[0];
                  wb_dat_out[arhost_pkg::STAT_RUN1_BIT] <= started[1];
               end
               arhost_pkg::REG_QUERY: wb_dat_out <= query_status;
               arhost_pkg::REG_FILLED: wb_dat_out <= {16'h0000, query_filled};
               default: ;
            endcase
         end
      end
   end

   // Software-written configuration
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         irq_on <= 1'b0;
         buf_addr <= '0;
         buf_size <= '0;
         ctx_base[0] <= '0;
         ctx_base[1] <= '0;
      end else if (wb_wr) begin
         case (wb_adr_in)
            arhost_pkg::REG_CTRL: if (wb_sel_in[0]) irq_on <= wb_dat_in[arhost_pkg::CTRL_IRQ_BIT];
            arhost_pkg::REG_BUF_ADDR: buf_addr <= merge_sel(buf_addr, wb_dat_in, wb_sel_in);
            arhost_pkg::REG_BUF_SIZE: buf_size <= 16'(merge_sel({16'h0000, buf_size}, wb_dat_in, wb_sel_in));
            arhost_pkg::REG_REQ_BASE: ctx_base[0] <= merge_sel(ctx_base[0], wb_dat_in, wb_sel_in);
            arhost_pkg::REG_RSP_BASE: ctx_base[1] <= merge_sel(ctx_base[1], wb_dat_in, wb_sel_in);
            default: ;
         endcase
      end
   end

   // Command capture, only while idle
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         cmd_code <= 4'h0;
         cmd_ctx <= 1'b0;
         cmd_idx <= '0;
         cmd_go <= 1'b0;
      end else begin
         cmd_go <= 1'b0;
         if (wb_wr && wb_adr_in == arhost_pkg::REG_CMD && wb_sel_in[1:0] == 2'b11 && st == ST_IDLE && !cmd_go) begin
            cmd_code <= wb_dat_in[3:0];
            cmd_ctx <= wb_dat_in[arhost_pkg::CMD_CTX_BIT];
            cmd_idx <= wb_dat_in[arhost_pkg::CMD_IDX_LSB +: DESC_IDX_W];
            cmd_go <= 1'b1;
         end
      end
   end

   // Sticky error, set wins
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         err <= 1'b0;
      end else begin
         if (wb_wr && wb_adr_in == arhost_pkg::REG_STATUS && wb_sel_in[2] && wb_dat_in[arhost_pkg::STAT_ERR_BIT]) begin
            err <= 1'b0;
         end
         if (refuse || (wb_wr && wb_adr_in == arhost_pkg::REG_CMD && (st != ST_IDLE || cmd_go))) begin
            err <= 1'b1;
         end
      end
   end

   // Memory and device sequencer
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         st <= ST_IDLE;
         op_code <= '0;
         op_ctx <= '0;
         quad <= '0;
         refuse <= '0;
         mem_req_out <= '0;
         mem_we_out <= '0;
         mem_addr_out <= '0;
         mem_wdata_out <= '0;
         dev_req_out <= '0;
         dev_addr_out <= '0;
         dev_wdata_out <= '0;
         query_status <= '0;
         query_filled <= '0;
         size_q <= '0;
      end else begin
         refuse <= 1'b0;
         case (st)
            ST_IDLE: begin
               if (cmd_go) begin
                  op_code <= cmd_code;
                  op_ctx <= cmd_ctx;
                  quad <= 2'h0;
                  case (cmd_code)
                     arhost_pkg::CMD_APPEND: if (append_bad) refuse <= 1'b1; else st <= ST_DESC_WR;
                     arhost_pkg::CMD_START: if (started[cmd_ctx]) refuse <= 1'b1; else st <= ST_PTR_WR;
                     arhost_pkg::CMD_STOP: if (!started[cmd_ctx]) refuse <= 1'b1; else st <= ST_CLR_WR;
                     arhost_pkg::CMD_QUERY: begin
                        if ({1'b0, cmd_idx} >= desc_count[cmd_ctx]) refuse <= 1'b1;
                        else st <= ST_QUERY_RD;
                     end
                     default: refuse <= 1'b1;
                  endcase
               end
            end
            ST_DESC_WR: begin
               if (!mem_req_out) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= cur_desc + {28'h0, quad, 2'b00};
                  mem_wdata_out <= pack_q;
               end else if (mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  quad <= quad + 2'h1;
                  if (quad == 2'h3) begin
                     if (op_idx != '0) st <= ST_LINK_WR;
                     else if (started[op_ctx]) st <= ST_PTR_WR;
                     else st <= ST_FINISH;
                  end
               end
            end
            ST_LINK_WR: begin
               if (!mem_req_out) begin
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b1;
                  mem_addr_out <= desc_addr(ctx_base[op_ctx], op_idx - 1'b1) + arhost_pkg::DESC_NEXT_OFS;
                  mem_wdata_out <= {cur_desc[31:4], arhost_pkg::DESC_Z_MORE};
               end else if (mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  st <= started[op_ctx] ? ST_SET_WR : ST_FINISH;
               end
            end
            ST_PTR_WR: begin
               if (!dev_req_out) begin
                  dev_req_out <= 1'b1;
                  dev_addr_out <= dev_base + arhost_pkg::DEV_PTR_OFS;
                  dev_wdata_out <= {ctx_base[op_ctx][31:4], 3'b000,
                     (op_code == arhost_pkg::CMD_APPEND) || (op_idx != '0)};
               end else if (dev_ack_in) begin
                  dev_req_out <= 1'b0;
                  st <= ST_SET_WR;
               end
            end
            ST_SET_WR: begin
               if (!dev_req_out) begin
                  dev_req_out <= 1'b1;
                  dev_addr_out <= dev_base + arhost_pkg::DEV_SET_OFS;
                  dev_wdata_out <= (op_code == arhost_pkg::CMD_APPEND) ? arhost_pkg::DEV_WAKE_MASK
                     : arhost_pkg::DEV_RUN_MASK;
               end else if (dev_ack_in) begin
                  dev_req_out <= 1'b0;
                  st <= ST_FINISH;
               end
            end
            ST_CLR_WR: begin
               if (!dev_req_out) begin
                  dev_req_out <= 1'b1;
                  dev_addr_out <= dev_base + arhost_pkg::DEV_CLR_OFS;
                  dev_wdata_out <= arhost_pkg::DEV_RUN_MASK;
               end else if (dev_ack_in) begin
                  dev_req_out <= 1'b0;
                  st <= ST_FINISH;
               end
            end
            ST_QUERY_RD: begin
               if (!mem_req_out) begin
                  size_q <= size_rd;
                  mem_req_out <= 1'b1;
                  mem_we_out <= 1'b0;
                  mem_addr_out <= desc_addr(ctx_base[op_ctx], {1'b0, cmd_idx}) + arhost_pkg::DESC_RESID_OFS;
               end else if (mem_ack_in) begin
                  mem_req_out <= 1'b0;
                  query_status <= mem_rdata_in;
                  st <= ST_QUERY_FIN;
               end
            end
            ST_QUERY_FIN: begin
               query_filled <= size_q - query_status[15:0];
               st <= ST_IDLE;
            end
            ST_FINISH: st <= ST_IDLE;
            default: st <= ST_IDLE;
         endcase
      end
   end

   // Per-context bookkeeping
   always_ff @(posedge clk_sys_in or negedge rst_b) begin
      if (!rst_b) begin
         desc_count[0] <= '0;
         desc_count[1] <= '0;
         started[0] <= 1'b0;
         started[1] <= 1'b0;
      end else if (st == ST_FINISH) begin
         case (op_code)
            arhost_pkg::CMD_APPEND: desc_count[op_ctx] <= op_idx + 1'b1;
            arhost_pkg::CMD_START: started[op_ctx] <= 1'b1;
            arhost_pkg::CMD_STOP: begin
               started[op_ctx] <= 1'b0;
               desc_count[op_ctx] <= '0;
            end
            default: ;
         endcase
      end
   end
endmodule : arhost_ctrl

// ---- testbench/arhost_ctrl_checker.sv ----
// Port assertions for the receive-context host controller
`timescale 1ns/1ns
module arhost_ctrl_checker #(
   parameter int DEV_ADDR_W = 12
) (
   input wire logic clk_sys_in,
   input wire logic rst_b_in,
   input wire logic wb_cyc_in,
   input wire logic wb_stb_in,
   input wire logic wb_ack_out,
   input wire logic [31:0] wb_dat_out,
   input wire logic mem_req_out,
   input wire logic mem_we_out,
   input wire logic [31:0] mem_addr_out,
   input wire logic [31:0] mem_wdata_out,
   input wire logic mem_ack_in,
   input wire logic dev_req_out,
   input wire logic [DEV_ADDR_W-1:0] dev_addr_out,
   input wire logic [31:0] dev_wdata_out,
   input wire logic dev_ack_in
);
   default clocking cb @(posedge clk_sys_in);
   endclocking
   default disable iff (!rst_b_in);
   logic [15:0] size_seen;
   wire wr = mem_req_out && mem_we_out;
   wire [3:0] ofs = mem_addr_out[3:0];
   wire [31:0] wd = mem_wdata_out;
   // Buffer size of the descriptor being written
   always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         size_seen <= 16'h0;
      end else if (wr && mem_ack_in && ofs == 4'h0) begin
         size_seen <= wd[15:0];
      end
   end
   a_wb_answer: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out) else $error("no bus ack");
   a_wb_pulse: assert property (wb_ack_out |=> !wb_ack_out && wb_dat_out == 32'h0) else $error("ack not a pulse");
   a_mem_hold: assert property (mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out) && $stable(wd)
      && $stable(mem_we_out)) else $error("mem req changed");
   a_mem_release: assert property (mem_req_out && mem_ack_in |=> !mem_req_out) else $error("mem req kept");
   a_desc_fields: assert property (wr && ofs == 4'h0 |-> wd[31:22] == 10'h0A0 && wd[19:16] == 4'hC
      && wd[1:0] == 2'h0) else $error("bad descriptor word");
   a_irq_code: assert property (wr && ofs == 4'h0 |-> wd[21] == wd[20]) else $error("bad interrupt code");
   a_buf_align: assert property (wr && ofs == 4'h4 |-> wd[1:0] == 2'h0) else $error("buffer unaligned");
   a_link_code: assert property (wr && ofs == 4'h8 |-> wd[3:1] == 3'h0) else $error("bad link word");
   a_resid_init: assert property (wr && ofs == 4'hC |-> wd == {16'h0, size_seen}) else $error("bad count");
   a_dev_hold: assert property (dev_req_out && !dev_ack_in |=> dev_req_out && $stable(dev_addr_out)
      && $stable(dev_wdata_out)) else $error("dev req changed");
   a_dev_release: assert property (dev_req_out && dev_ack_in |=> !dev_req_out) else $error("dev req kept");
   a_ptr_code: assert property (dev_req_out && dev_addr_out[3:0] == 4'hC |-> dev_wdata_out[3:1] == 3'h0)
      else $error("bad start pointer");
endmodule : arhost_ctrl_checker

bind arhost_ctrl arhost_ctrl_checker #(.DEV_ADDR_W(DEV_ADDR_W)) u_chk (.*);

// ---- testbench/arhost_dev_model.sv ----
// Receive device and host memory model
`timescale 1ns/1ns
module arhost_dev_model (
   input wire logic clk_sys_in,
   input wire logic [1:0] lat_in,
   input wire logic mem_req_in,
   input wire logic mem_we_in,
   input wire logic [31:0] mem_addr_in,
   input wire logic [31:0] mem_wdata_in,
   output logic [31:0] mem_rdata_out,
   output logic mem_ack_out,
   input wire logic dev_req_in,
   input wire logic [11:0] dev_addr_in,
   input wire logic [31:0] dev_wdata_in,
   output logic dev_ack_out
);
   logic [31:0] mem [logic [31:0]];
   logic [31:0] ctl [2] = '{32'h0, 32'h0};
   logic [31:0] ptr [2] = '{32'h0, 32'h0};
   logic [31:0] cur [2] = '{32'h0, 32'h0};
   logic [31:0] rd = 32'h0;
   logic [1:0] mcnt = 2'h0, dcnt = 2'h0;
   int c, irqs = 0;
   initial begin
      mem_ack_out = 1'b0;
      dev_ack_out = 1'b0;
   end
   // Released read bus shows the inverse
   assign mem_rdata_out = mem_ack_out ? rd : ~rd;
   always @(posedge clk_sys_in) begin
      mem_ack_out <= 1'b0;
      if (mem_req_in && !mem_ack_out) begin
         mcnt <= mcnt + 2'h1;
         if (mcnt == lat_in) begin
            mcnt <= 2'h0;
            mem_ack_out <= 1'b1;
            if (mem_we_in) mem[mem_addr_in] = mem_wdata_in;
            else rd <= mem.exists(mem_addr_in) ? mem[mem_addr_in] : 32'h0;
         end
      end
   end
   always @(posedge clk_sys_in) begin
      dev_ack_out <= 1'b0;
      if (dev_req_in && !dev_ack_out) begin
         dcnt <= dcnt + 2'h1;
         if (dcnt == lat_in) begin
            dcnt <= 2'h0;
            dev_ack_out <= 1'b1;
            c = int'(dev_addr_in >= arhost_pkg::DEV_RSP_BASE);
            case (dev_addr_in[3:0])
               4'h0: ctl[c] = ctl[c] | dev_wdata_in;
               4'h4: ctl[c] = ctl[c] & ~dev_wdata_in;
               4'hC: ptr[c] = dev_wdata_in;
               default: ;
            endcase
            if (dev_addr_in[3:0] == 4'h0 && ctl[c][15] && cur[c] == 32'h0 && ptr[c][0])
               cur[c] = {ptr[c][31:4], 4'h0};
         end
      end
   end
   // Pours one packet; every descriptor taken as buffer-fill
   task automatic deliver(input int k, input int len, input bit err);
      logic [31:0] d;
      logic [15:0] res;
      int take;
      if (err) return;
      while (len > 0 && cur[k] != 32'h0) begin
         d = cur[k];
         res = mem[d + 32'hC][15:0];
         if (res == 16'h0) begin
            if (mem[d + 32'h8][3:0] != 4'h1) return;
            cur[k] = {mem[d + 32'h8][31:4], 4'h0};
         end else begin
            take = len < int'(res) ? len : int'(res);
            len -= take;
            if (mem[d][21:20] == 2'h3 && take == int'(res)) irqs++;
            mem[d + 32'hC] = {ctl[k][15:0], res - 16'(take)};
         end
      end
   endtask : deliver
endmodule : arhost_dev_model

// ---- testbench/arhost_ctrl_tb_top.sv ----
// Self-checking bench for the receive-context host controller
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
$display("Error %s expected %h seen %h", n, e, s); end end
module arhost_ctrl_tb_top;
   logic clk = 1'b0, rst_b = 1'b0, cyc = 1'b0, we = 1'b0, ack, m_req, m_we, m_ack, d_req, d_ack;
   logic [7:0] adr = 8'h0;
   logic [31:0] dat = 32'h0, rdat, m_adr, m_wd, m_rd, d_wd, q;
   logic [11:0] d_adr;
   logic [1:0] lat = 2'h0;
   logic [3:0] bad [4] = '{arhost_pkg::CMD_APPEND, arhost_pkg::CMD_START, arhost_pkg::CMD_QUERY, 4'hF};
   logic [31:0] base [2], ba [2][4];
   logic irq [2][4];
   int fail_count = 0, checks_done = 0, tot [2] = '{0, 0}, sz [2][4], pc, pl;
   initial forever #5 clk = ~clk;
   arhost_ctrl DUT (.clk_sys_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(cyc), .wb_we_in(we),
      .wb_adr_in(adr), .wb_dat_in(dat), .wb_sel_in(4'hF), .wb_dat_out(rdat), .wb_ack_out(ack),
      .mem_req_out(m_req), .mem_we_out(m_we), .mem_addr_out(m_adr), .mem_wdata_out(m_wd), .mem_rdata_in(m_rd),
      .mem_ack_in(m_ack), .dev_req_out(d_req), .dev_addr_out(d_adr), .dev_wdata_out(d_wd), .dev_ack_in(d_ack));
   arhost_dev_model M (.clk_sys_in(clk), .lat_in(lat), .mem_req_in(m_req), .mem_we_in(m_we),
      .mem_addr_in(m_adr), .mem_wdata_in(m_wd), .mem_rdata_out(m_rd), .mem_ack_out(m_ack),
      .dev_req_in(d_req), .dev_addr_in(d_adr), .dev_wdata_in(d_wd), .dev_ack_out(d_ack));
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : results
   task automatic bound(input int n);
      if (n >= 40) begin
         fail_count++;
         results();
      end
   endtask : bound
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      q = rdat;
      cyc <= 1'b0;
      bound(n);
   endtask : wb
   task automatic cmd(input logic [3:0] code, input int c, input int k);
      int n = 0;
      wb(1'b1, arhost_pkg::REG_CMD, {20'h0, 4'(k), 3'h0, 1'(c), code});
      do begin
         wb(1'b0, arhost_pkg::REG_STATUS, 32'h0);
         n++;
      end while (q[arhost_pkg::STAT_BUSY_BIT] !== 1'b0 && n < 40);
      bound(n);
   endtask : cmd
   task automatic append(input int c, input int k, input int s);
      ba[c][k] = $urandom & 32'h00FF_FFFC;
      sz[c][k] = s;
      irq[c][k] = 1'($urandom);
      lat <= 2'($urandom);
      wb(1'b1, arhost_pkg::REG_BUF_ADDR, ba[c][k]);
      wb(1'b1, arhost_pkg::REG_BUF_SIZE, 32'(s));
      wb(1'b1, arhost_pkg::REG_CTRL, {31'h0, irq[c][k]});
      cmd(arhost_pkg::CMD_APPEND, c, 0);
   endtask : append
   function automatic logic [31:0] q0(logic i, logic [15:0] s);
      return {4'h2, 1'b1, 3'h0, 2'h0, {2{i}}, 2'h3, 2'h0, s};
   endfunction : q0
   function automatic int pre(int c, int k);
      int s = 0;
      for (int j = 0; j < k; j++)
         s += sz[c][j];
      return s;
   endfunction : pre
   function automatic int fill(int c, int k);
      int f = tot[c] - pre(c, k);
      return f < 0 ? 0 : (f > sz[c][k] ? sz[c][k] : f);
   endfunction : fill
   initial begin
      void'($urandom(42));
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge clk);
      wb(1'b1, arhost_pkg::REG_BUF_ADDR, 32'h0000_1234);
      wb(1'b0, arhost_pkg::REG_BUF_ADDR, 32'h0);
      `CHK("buf_addr", 32'h0000_1234, q)
      wb(1'b0, 8'hF0, 32'h0);
      `CHK("unmapped", 32'h0, q)
      $display("test registers done");
      // Req started after build, rsp before
      for (int c = 0; c < 2; c++) begin
         base[c] = 32'h0001_0000 * (c + 1) + 32'($urandom % 16) * 32'h10;
         wb(1'b1, c ? arhost_pkg::REG_RSP_BASE : arhost_pkg::REG_REQ_BASE, base[c]);
         if (c == 1) begin
            cmd(arhost_pkg::CMD_START, 1, 0);
            `CHK("empty_ptr", 1'b0, M.ptr[1][0])
         end
         for (int k = 0; k < 4; k++) begin
            append(c, k, k == 0 ? 4 : int'($urandom % 16 + 1) * 4);
            `CHK("count", 5'(k + 1), c ? q[12:8] : q[4:0])
         end
         if (c == 0) cmd(arhost_pkg::CMD_START, 0, 0);
         `CHK("ptr", {base[c][31:4], 4'h1}, M.ptr[c])
         `CHK("run", 1'b1, M.ctl[c][15])
         for (int k = 0; k < 4; k++) begin
            `CHK("q0", q0(irq[c][k], 16'(sz[c][k])), M.mem[base[c] + 16 * k])
            `CHK("q1", ba[c][k], M.mem[base[c] + 16 * k + 4])
            `CHK("q2", k < 3 ? {base[c][31:4] + 28'(k + 1), 4'h1} : 32'h0, M.mem[base[c] + 16 * k + 8])
            `CHK("q3", 32'(sz[c][k]), M.mem[base[c] + 16 * k + 12])
         end
      end
      `CHK("wake", 1'b1, M.ctl[1][12])
      $display("test programs done");
      wb(1'b1, arhost_pkg::REG_BUF_SIZE, 32'h0000_0006);
      foreach (bad[i]) begin
         cmd(bad[i], 0, 15);
         `CHK("err", 1'b1, q[16])
         wb(1'b1, arhost_pkg::REG_STATUS, 32'h0001_0000);
         wb(1'b0, arhost_pkg::REG_STATUS, 32'h0);
         `CHK("err_clear", 6'h04, {q[16], q[4:0]})
      end
      $display("test refusals done");
      for (int p = 0; p < 10; p++) begin
         pc = $urandom % 2;
         pl = int'($urandom % 10 + 1) * 4;
         if (tot[pc] + pl <= pre(pc, 4)) begin
            M.deliver(pc, pl, p == 3);
            if (p != 3) tot[pc] += pl;
         end
      end
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 4; k++) begin
            cmd(arhost_pkg::CMD_QUERY, c, k);
            wb(1'b0, arhost_pkg::REG_FILLED, 32'h0);
            `CHK("filled", 32'(fill(c, k)), q)
            wb(1'b0, arhost_pkg::REG_QUERY, 32'h0);
            `CHK("status", fill(c, k) > 0 ? (c ? 16'h9000 : 16'h8000) : 16'h0, q[31:16])
         end
      end
      $display("test packets done");
      cmd(arhost_pkg::CMD_STOP, 0, 0);
      `CHK("stopped", 6'h00, {M.ctl[0][15], q[4:0]})
      cmd(arhost_pkg::CMD_STOP, 0, 0);
      `CHK("stop_idle", 1'b1, q[16])
      $display("test stop done");
      results();
   end
endmodule : arhost_ctrl_tb_top
